// [tsf_defs.svh]
// Purpose: offsets, field positions and reset values of the status block
// Assumes: 32-bit word-aligned byte addresses on the register bus
// Notes:   definitions only
`ifndef TSF_DEFS_SVH
`define TSF_DEFS_SVH

// register byte offsets
`define TSF_OFS_STATUS   4'h0
`define TSF_OFS_MCODE    4'h4
`define TSF_OFS_CTRL     4'h8

// status word field positions
`define TSF_B_AUTO       2
`define TSF_B_MANUAL     3
`define TSF_B_RUN        4
`define TSF_B_DONE       5
`define TSF_B_OPT_WAIT   6
`define TSF_B_MRST_WAIT  7
`define TSF_B_MSTROBE    8
`define TSF_B_CSTART     9
`define TSF_B_T_DONE     13
`define TSF_B_T_ERR      14
`define TSF_B_T_OVER     15

// control word field positions
`define TSF_C_MRST       0

// reset values and limits
`define TSF_STATUS_RST   16'h0000
`define TSF_MCODE_RST    16'h0000
`define TSF_MCODE_MAX    16'h03e7

`endif

// [tsf_pkg.sv]
// Purpose: shared types of the task status block
// Assumes: nothing
// Notes:   constants live in tsf_defs.svh
package tsf_pkg;

    // operating mode code reported by the unit
    typedef enum logic [1:0] {
        TSF_MODE_OTHER  = 2'h0,
        TSF_MODE_AUTO   = 2'h1,
        TSF_MODE_MANUAL = 2'h2
    } tsf_mode_e;

    // bus slave states, one-hot
    typedef enum logic [1:0] {
        TSF_ST_IDLE = 2'h1,
        TSF_ST_ACK  = 2'h2
    } tsf_bus_st_e;

    typedef logic [15:0] tsf_word_t;

endpackage

// [tsf_reg_if.sv]
// Purpose: register access strobes between bus slave and status core
// Assumes: single clock
// Notes:   wr_stb is a one-cycle pulse on the completing edge
`timescale 1ns/1ps
interface tsf_reg_if #(
    parameter int AW = 4
);
    logic          wr_stb;
    logic [AW-1:0] addr;
    logic [31:0]   wdata;
    logic [31:0]   rdata;

    modport slave (
        output wr_stb,
        output addr,
        output wdata,
        input  rdata
    );
    modport core (
        input  wr_stb,
        input  addr,
        input  wdata,
        output rdata
    );
endinterface

// [tsf_teach.sv]
// Purpose: teaching completed, error and address-over flags
// Assumes: all inputs come from logic on the same clock
// Notes:   a set in the same cycle as a clear wins
`timescale 1ns/1ps
module tsf_teach (
    input  wire logic clock,
    input  wire logic arst_n,
    input  wire logic teach_cmd,
    input  wire logic teach_done,
    input  wire logic teach_ok,
    input  wire logic teach_err,
    input  wire logic teach_addr_over,
    input  wire logic teach_addr_set_done,
    output logic      t_done_reg,
    output logic      t_err_reg,
    output logic      t_over_reg
);
    logic cmd_prev_reg;
    logic cmd_fall;
    logic err_clear;

    assign cmd_fall  = cmd_prev_reg && !teach_cmd;
    assign err_clear = teach_ok || teach_addr_set_done;

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            cmd_prev_reg <= 1'b0;
        end else begin
            cmd_prev_reg <= teach_cmd;
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            t_done_reg <= 1'b0;
        end else if (teach_done) begin
            t_done_reg <= 1'b1;
        end else if (cmd_fall) begin
            t_done_reg <= 1'b0;
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            t_err_reg  <= 1'b0;
            t_over_reg <= 1'b0;
        end else begin
            if (teach_err) begin
                t_err_reg <= 1'b1;
            end else if (err_clear) begin
                t_err_reg <= 1'b0;
            end
            if (teach_addr_over) begin
                t_over_reg <= 1'b1;
            end else if (err_clear) begin
                t_over_reg <= 1'b0;
            end
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);

    t_done_set_a: assert property (teach_done |=> t_done_reg)
        else $error("teach done flag not set");
    t_done_clr_a: assert property (
        $fell(teach_cmd) && !teach_done |=> !t_done_reg)
        else $error("teach done flag not cleared on command off");
    t_err_clr_a: assert property (
        !teach_err && (teach_ok || teach_addr_set_done) |=> !t_err_reg)
        else $error("teach error flag not cleared");
    t_over_hold_a: assert property (
        teach_addr_over ##1 (!err_clear)[*2] |=> t_over_reg)
        else $error("address over flag lost");
    t_err_cv: cover property (teach_err ##[1:20] teach_ok);
endmodule

// [tsf_avs.sv]
// Purpose: Avalon-MM slave front end, one wait cycle per access
// Assumes: master holds its request until waitrequest is low
// Notes:   readdata is captured in the wait cycle
`timescale 1ns/1ps
module tsf_avs #(
    parameter int AW = 4
) (
    input  wire logic          clock,
    input  wire logic          arst_n,
    input  wire logic [AW-1:0] address,
    input  wire logic          read,
    input  wire logic          write,
    input  wire logic [31:0]   writedata,
    output logic               waitrequest,
    output logic [31:0]        readdata,
    tsf_reg_if.slave           rif
);
    tsf_pkg::tsf_bus_st_e state_reg;
    logic                 req;

    assign req         = read || write;
    assign waitrequest = state_reg[0];
    assign rif.addr    = address;
    assign rif.wdata   = writedata;
    assign rif.wr_stb  = write && (state_reg == tsf_pkg::TSF_ST_ACK);

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            state_reg <= tsf_pkg::TSF_ST_IDLE;
        end else begin
            case (state_reg)
                tsf_pkg::TSF_ST_IDLE: begin
                    if (req) begin
                        state_reg <= tsf_pkg::TSF_ST_ACK;
                    end
                end
                tsf_pkg::TSF_ST_ACK: begin
                    state_reg <= tsf_pkg::TSF_ST_IDLE;
                end
                default: begin
                    state_reg <= tsf_pkg::TSF_ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            readdata <= 32'h0000_0000;
        end else if (read && state_reg == tsf_pkg::TSF_ST_IDLE) begin
            readdata <= rif.rdata;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);

    bus_wait_a: assert property (req && waitrequest |=> !waitrequest)
        else $error("access not answered after one wait cycle");
    bus_idle_a: assert property (!req |=> waitrequest)
        else $error("waitrequest low without request");
endmodule

// [tsf_top.sv]
// Purpose: read-only status word of one motion task, over Avalon-MM
// Assumes: unit status inputs are on clock; cycle_start is a pin
// Notes:   auxiliary code word and a control word sit beside the status
//
// Implementation choices: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "tsf_defs.svh"
module tsf_top #(
    parameter int AW = 4
) (
    input  wire logic                clock,
    input  wire logic                arst_n,
    input  wire logic [AW-1:0]       address,
    input  wire logic                read,
    input  wire logic                write,
    input  wire logic [31:0]         writedata,
    output logic                     waitrequest,
    output logic [31:0]              readdata,
    input  wire tsf_pkg::tsf_mode_e  unit_mode,
    input  wire logic                prog_running,
    input  wire logic                program_end_instruction,
    input  wire logic                opt_input_wait,
    input  wire logic                mcode_reset_wait,
    input  wire logic                mcode_valid,
    input  wire logic [15:0]         mcode_value,
    input  wire logic                mcode_reset,
    input  wire logic                cycle_start,
    input  wire logic                teach_cmd,
    input  wire logic                teach_done,
    input  wire logic                teach_ok,
    input  wire logic                teach_err,
    input  wire logic                teach_addr_over,
    input  wire logic                teach_addr_set_done,
    output tsf_pkg::tsf_word_t       task_status_flags,
    output tsf_pkg::tsf_word_t       mcode_word
);
    tsf_reg_if #(.AW(AW)) rif ();

    logic auto_reg;
    logic manual_reg;
    logic run_reg;
    logic run_prev_reg;
    logic done_reg;
    logic opt_wait_reg;
    logic mrst_wait_reg;
    logic mstrobe_reg;
    logic cs_meta_reg;
    logic cs_sync_reg;
    logic cs_prev_reg;
    logic cs_flag_reg;
    logic t_done_reg;
    logic t_err_reg;
    logic t_over_reg;
    logic sw_mrst;
    logic mcode_set;
    logic mcode_clr;
    logic run_start;
    tsf_pkg::tsf_word_t mcode_reg;

    function automatic logic hit(input logic [AW-1:0] a,
                                 input logic [AW-1:0] ofs);
        hit = (a == ofs);
    endfunction

    tsf_avs #(.AW(AW)) u_avs (
        .clock       (clock),
        .arst_n      (arst_n),
        .address     (address),
        .read        (read),
        .write       (write),
        .writedata   (writedata),
        .waitrequest (waitrequest),
        .readdata    (readdata),
        .rif         (rif.slave)
    );

    tsf_teach u_teach (
        .clock               (clock),
        .arst_n              (arst_n),
        .teach_cmd           (teach_cmd),
        .teach_done          (teach_done),
        .teach_ok            (teach_ok),
        .teach_err           (teach_err),
        .teach_addr_over     (teach_addr_over),
        .teach_addr_set_done (teach_addr_set_done),
        .t_done_reg          (t_done_reg),
        .t_err_reg           (t_err_reg),
        .t_over_reg          (t_over_reg)
    );

    // unused positions are constant zero; status takes no writes
    assign task_status_flags = {t_over_reg, t_err_reg, t_done_reg,
                                3'h0,
                                cs_flag_reg, mstrobe_reg, mrst_wait_reg,
                                opt_wait_reg, done_reg, run_reg,
                                manual_reg, auto_reg,
                                2'h0};
    assign mcode_word        = mcode_reg;

    // software write of 1 to the control word clears the auxiliary code strobe
    assign sw_mrst   = rif.wr_stb && hit(rif.addr, `TSF_OFS_CTRL)
                       && rif.wdata[`TSF_C_MRST];
    assign mcode_set = mcode_valid && (mcode_value <= `TSF_MCODE_MAX);
    assign mcode_clr = mcode_reset || sw_mrst;
    assign run_start = prog_running && !run_prev_reg;

    always_comb begin
        rif.rdata = 32'h0000_0000;
        if (hit(rif.addr, `TSF_OFS_STATUS)) begin
            rif.rdata = {16'h0000, task_status_flags};
        end else if (hit(rif.addr, `TSF_OFS_MCODE)) begin
            rif.rdata = {16'h0000, mcode_reg};
        end
    end

    // mode flags
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            auto_reg   <= 1'b0;
            manual_reg <= 1'b0;
        end else begin
            auto_reg   <= (unit_mode == tsf_pkg::TSF_MODE_AUTO);
            manual_reg <= (unit_mode == tsf_pkg::TSF_MODE_MANUAL);
        end
    end

    // program execution and completion
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            run_reg      <= 1'b0;
            run_prev_reg <= 1'b0;
        end else begin
            run_reg      <= prog_running;
            run_prev_reg <= prog_running;
        end
    end

    // completion stays until the next program start
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            done_reg <= 1'b0;
        end else if (program_end_instruction) begin
            done_reg <= 1'b1;
        end else if (run_start) begin
            done_reg <= 1'b0;
        end
    end

    // pause reasons
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            opt_wait_reg  <= 1'b0;
            mrst_wait_reg <= 1'b0;
        end else begin
            opt_wait_reg  <= opt_input_wait;
            mrst_wait_reg <= mcode_reset_wait;
        end
    end

    // auxiliary code and its strobe; an output beats a reset
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            mstrobe_reg <= 1'b0;
            mcode_reg   <= `TSF_MCODE_RST;
        end else if (mcode_set) begin
            mstrobe_reg <= 1'b1;
            mcode_reg   <= mcode_value;
        end else if (mcode_clr) begin
            mstrobe_reg <= 1'b0;
        end
    end

    // cycle start pin synchroniser
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            cs_meta_reg <= 1'b0;
            cs_sync_reg <= 1'b0;
            cs_prev_reg <= 1'b0;
        end else begin
            cs_meta_reg <= cycle_start;
            cs_sync_reg <= cs_meta_reg;
            cs_prev_reg <= cs_sync_reg;
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            cs_flag_reg <= 1'b0;
        end else if (cs_sync_reg && !cs_prev_reg) begin
            cs_flag_reg <= 1'b1;
        end else if (!cs_sync_reg) begin
            cs_flag_reg <= 1'b0;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);

    auto_flag_a: assert property (
        unit_mode == tsf_pkg::TSF_MODE_AUTO
        |=> task_status_flags[`TSF_B_AUTO]
            && !task_status_flags[`TSF_B_MANUAL])
        else $error("automatic flag wrong");
    manual_flag_a: assert property (
        unit_mode != tsf_pkg::TSF_MODE_MANUAL
        |=> !task_status_flags[`TSF_B_MANUAL])
        else $error("manual flag high outside manual mode");
    run_flag_a: assert property (
        prog_running != $past(prog_running)
        |=> task_status_flags[`TSF_B_RUN] == $past(prog_running))
        else $error("run flag does not follow program state");
    done_set_a: assert property (
        program_end_instruction ##1 (!run_start)[*3]
        |=> task_status_flags[`TSF_B_DONE])
        else $error("completion flag not held");
    opt_wait_a: assert property (
        opt_input_wait |=> task_status_flags[`TSF_B_OPT_WAIT])
        else $error("optional input wait flag missing");
    mrst_wait_a: assert property (
        !mcode_reset_wait |=> !task_status_flags[`TSF_B_MRST_WAIT])
        else $error("code reset wait flag stuck");
    mstrobe_set_a: assert property (
        mcode_set |=> mstrobe_reg && mcode_word == $past(mcode_value))
        else $error("auxiliary code strobe or word not set");
    mstrobe_range_a: assert property (
        mcode_valid && mcode_value > `TSF_MCODE_MAX && !mstrobe_reg
        && !mcode_set |=> !mstrobe_reg)
        else $error("strobe set for out of range code");
    mstrobe_clr_a: assert property (
        mcode_clr && !mcode_set |=> !task_status_flags[`TSF_B_MSTROBE])
        else $error("strobe not cleared by code reset");
    cstart_on_a: assert property (
        !cycle_start ##1 cycle_start[*3]
        |=> task_status_flags[`TSF_B_CSTART])
        else $error("cycle start receipt not flagged");
    cstart_off_a: assert property (
        (!cycle_start)[*3] |=> !task_status_flags[`TSF_B_CSTART])
        else $error("cycle start flag not cleared");
    unused_zero_a: assert property (
        task_status_flags[12:10] == 3'h0 && task_status_flags[1:0] == 2'h0)
        else $error("unused status bits not zero");
    auto_clr_a: assert property (
        unit_mode != tsf_pkg::TSF_MODE_AUTO
        |=> !task_status_flags[`TSF_B_AUTO])
        else $error("automatic flag high outside automatic mode");
    manual_set_a: assert property (
        unit_mode == tsf_pkg::TSF_MODE_MANUAL
        |=> task_status_flags[`TSF_B_MANUAL]
            && !task_status_flags[`TSF_B_AUTO])
        else $error("manual flag wrong");
    run_clr_a: assert property (
        !prog_running |=> !task_status_flags[`TSF_B_RUN])
        else $error("run flag high while program stopped");
    done_clr_a: assert property (
        $rose(prog_running) && !program_end_instruction
        |=> !task_status_flags[`TSF_B_DONE])
        else $error("completion flag kept over program start");
    opt_wait_clr_a: assert property (
        !opt_input_wait |=> !task_status_flags[`TSF_B_OPT_WAIT])
        else $error("optional input wait flag stuck");
    mrst_wait_set_a: assert property (
        mcode_reset_wait |=> task_status_flags[`TSF_B_MRST_WAIT])
        else $error("code reset wait flag missing");
    mcode_keep_a: assert property (
        !(mcode_valid && mcode_value <= `TSF_MCODE_MAX)
        |=> $stable(mcode_word))
        else $error("auxiliary code word changed without a valid code");
    mstrobe_hold_a: assert property (
        task_status_flags[`TSF_B_MSTROBE] && !mcode_reset && !sw_mrst
        |=> task_status_flags[`TSF_B_MSTROBE])
        else $error("strobe lost without a code reset");
    cstart_hold_a: assert property (
        task_status_flags[`TSF_B_CSTART] && $past(cycle_start, 2)
        |=> task_status_flags[`TSF_B_CSTART])
        else $error("cycle start flag dropped while signal on");
    stat_read_a: assert property (
        read && waitrequest && hit(address, `TSF_OFS_STATUS)
        |=> readdata == {16'h0000, $past(task_status_flags)})
        else $error("status read returned wrong word");
    unmapped_rd_a: assert property (
        read && waitrequest && !hit(address, `TSF_OFS_STATUS)
        && !hit(address, `TSF_OFS_MCODE)
        |=> readdata == 32'h0000_0000)
        else $error("unmapped or control read not zero");
    mcode_read_a: assert property (
        read && waitrequest && hit(address, `TSF_OFS_MCODE)
        |=> readdata == {16'h0000, $past(mcode_word)})
        else $error("code word read returned wrong value");

    strobe_cv: cover property (mcode_set ##[1:20] sw_mrst);
    cycle_cv: cover property ($rose(cs_flag_reg) ##[1:20] $fell(cs_flag_reg));
    prog_cv: cover property (run_start ##[1:50] program_end_instruction);
    mode_cv: cover property (auto_reg ##[1:20] manual_reg);
endmodule

// [tsf_host.sv]
// Purpose: host processor model reading the task status block
// Assumes: Avalon-MM master, one request at a time, no fixed latency
// Notes:   the bench calls the tasks; read and write are low when idle
`timescale 1ns/1ps
`include "tsf_defs.svh"
module tsf_host (
    input  wire logic        clock,
    output logic [3:0]       address,
    output logic             read,
    output logic             write,
    output logic [31:0]      writedata,
    input  wire logic        waitrequest,
    input  wire logic [31:0] readdata
);
    initial begin
        address   = 4'h0;
        read      = 1'b0;
        write     = 1'b0;
        writedata = 32'h0000_0000;
    end

    // request held until waitrequest is sampled low
    task automatic xfer(input logic [3:0] a, input logic w,
                        input logic [31:0] wd, output logic [31:0] rd);
        @(posedge clock);
        address   <= a;
        writedata <= wd;
        read      <= ~w;
        write     <= w;
        do @(posedge clock); while (waitrequest !== 1'b0);
        rd = readdata;
        read  <= 1'b0;
        write <= 1'b0;
    endtask

    // code word is only fetched while the strobe reads set
    task automatic poll_code(output logic strobe, output logic [15:0] code);
        logic [31:0] d;
        xfer(`TSF_OFS_STATUS, 1'b0, 32'h0, d);
        strobe = d[`TSF_B_MSTROBE];
        code   = 16'h0000;
        if (d[`TSF_B_MSTROBE] === 1'b1) begin
            xfer(`TSF_OFS_MCODE, 1'b0, 32'h0, d);
            code = d[15:0];
        end
    endtask
endmodule

// [tb_task_status_flag_word.sv]
// Purpose: self-checking bench of the task status word
// Assumes: flags follow inputs in one edge, cycle start in three
// Notes:   exp_st mirrors the expected status word
`timescale 1ns/1ps
`include "tsf_defs.svh"
module tb_task_status_flag_word;
    logic               clock, arst_n, read, write, waitrequest;
    logic [3:0]         address;
    logic [31:0]        writedata, readdata, rd_data;
    tsf_pkg::tsf_mode_e unit_mode;
    logic               prog_running, program_end_instruction;
    logic               opt_input_wait, mcode_reset_wait, mcode_valid;
    logic               mcode_reset, cycle_start, teach_cmd, teach_done;
    logic               teach_ok, teach_err, teach_addr_over;
    logic               teach_addr_set_done, stb;
    logic [15:0]        mcode_value, code, exp_st;
    tsf_pkg::tsf_word_t task_status_flags, mcode_word;
    int                 mismatches, cmp_count;
    localparam int K_END = 0, K_MV = 1, K_MR = 2, K_TD = 3;
    localparam int K_TOK = 4, K_TER = 5, K_TOV = 6, K_TAS = 7;

    tsf_top tsf_top_i (
        .clock(clock), .arst_n(arst_n), .address(address), .read(read),
        .write(write), .writedata(writedata), .waitrequest(waitrequest),
        .readdata(readdata), .unit_mode(unit_mode),
        .prog_running(prog_running),
        .program_end_instruction(program_end_instruction),
        .opt_input_wait(opt_input_wait),
        .mcode_reset_wait(mcode_reset_wait), .mcode_valid(mcode_valid),
        .mcode_value(mcode_value), .mcode_reset(mcode_reset),
        .cycle_start(cycle_start), .teach_cmd(teach_cmd),
        .teach_done(teach_done), .teach_ok(teach_ok),
        .teach_err(teach_err), .teach_addr_over(teach_addr_over),
        .teach_addr_set_done(teach_addr_set_done),
        .task_status_flags(task_status_flags), .mcode_word(mcode_word)
    );

    tsf_host tsf_host_i (
        .clock(clock), .address(address), .read(read), .write(write),
        .writedata(writedata), .waitrequest(waitrequest),
        .readdata(readdata)
    );

    always #50 clock = ~clock;

    task automatic conclude;
        if (mismatches == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h, expected %h",
                     $time, got, exp);
        end
    endtask

    task automatic cmp_st;
        chk({16'h0000, task_status_flags}, {16'h0000, exp_st});
    endtask

    task automatic seen(input int n);
        repeat (n) @(posedge clock);
        @(negedge clock);
    endtask

    task automatic drive_pulse(input int k, input logic v);
        case (k)
            K_END: program_end_instruction <= v;
            K_MV:  mcode_valid <= v;
            K_MR:  mcode_reset <= v;
            K_TD:  teach_done <= v;
            K_TOK: teach_ok <= v;
            K_TER: teach_err <= v;
            K_TOV: teach_addr_over <= v;
            default: teach_addr_set_done <= v;
        endcase
    endtask

    task automatic pulse(input int k);
        @(posedge clock);
        drive_pulse(k, 1'b1);
        @(posedge clock);
        drive_pulse(k, 1'b0);
        @(negedge clock);
    endtask

    task automatic t_reset;
        exp_st = `TSF_STATUS_RST;
        cmp_st();
        tsf_host_i.xfer(`TSF_OFS_MCODE, 1'b0, 32'h0, rd_data);
        chk(rd_data, 32'h0000_0000);
        tsf_host_i.xfer(4'hc, 1'b0, 32'h0, rd_data);
        chk(rd_data, 32'h0000_0000);
    endtask

    task automatic t_mode;
        for (int i = 0; i < 4; i++) begin
            @(posedge clock);
            unit_mode <= tsf_pkg::tsf_mode_e'(i);
            seen(1);
            exp_st[`TSF_B_AUTO]   = (i == 1);
            exp_st[`TSF_B_MANUAL] = (i == 2);
            cmp_st();
        end
    endtask

    task automatic t_levels;
        @(posedge clock);
        prog_running <= 1'b1;
        seen(1);
        exp_st[`TSF_B_RUN] = 1'b1;
        cmp_st();
        @(posedge clock);
        opt_input_wait <= 1'b1;
        seen(1);
        exp_st[`TSF_B_OPT_WAIT] = 1'b1;
        cmp_st();
        @(posedge clock);
        mcode_reset_wait <= 1'b1;
        seen(1);
        exp_st[`TSF_B_MRST_WAIT] = 1'b1;
        cmp_st();
        @(posedge clock);
        opt_input_wait   <= 1'b0;
        mcode_reset_wait <= 1'b0;
        seen(1);
        exp_st[`TSF_B_OPT_WAIT]  = 1'b0;
        exp_st[`TSF_B_MRST_WAIT] = 1'b0;
        cmp_st();
    endtask

    task automatic t_done;
        pulse(K_END);
        exp_st[`TSF_B_DONE] = 1'b1;
        cmp_st();
        @(posedge clock);
        prog_running <= 1'b0;
        seen(3);
        exp_st[`TSF_B_RUN] = 1'b0;
        cmp_st();
        @(posedge clock);
        prog_running <= 1'b1;
        seen(1);
        exp_st[`TSF_B_RUN]  = 1'b1;
        exp_st[`TSF_B_DONE] = 1'b0;
        cmp_st();
    endtask

    task automatic t_mcode;
        @(posedge clock);
        mcode_value <= `TSF_MCODE_MAX;
        pulse(K_MV);
        exp_st[`TSF_B_MSTROBE] = 1'b1;
        cmp_st();
        tsf_host_i.poll_code(stb, code);
        chk({15'h0, stb, code}, {15'h0, 1'b1, 16'h03e7});
        pulse(K_MR);
        exp_st[`TSF_B_MSTROBE] = 1'b0;
        cmp_st();
        @(posedge clock);
        mcode_value <= 16'h03e8;
        pulse(K_MV);
        cmp_st();
        chk({16'h0, mcode_word}, 32'h0000_03e7);
        @(posedge clock);
        mcode_value <= 16'h0000;
        pulse(K_MV);
        exp_st[`TSF_B_MSTROBE] = 1'b1;
        cmp_st();
        tsf_host_i.xfer(`TSF_OFS_CTRL, 1'b1, 32'h0000_0001, rd_data);
        seen(1);
        exp_st[`TSF_B_MSTROBE] = 1'b0;
        cmp_st();
        tsf_host_i.poll_code(stb, code);
        chk({15'h0, stb, code}, 32'h0);
    endtask

    task automatic t_cstart;
        @(posedge clock);
        cycle_start <= 1'b1;
        seen(3);
        exp_st[`TSF_B_CSTART] = 1'b1;
        cmp_st();
        @(posedge clock);
        cycle_start <= 1'b0;
        seen(3);
        exp_st[`TSF_B_CSTART] = 1'b0;
        cmp_st();
    endtask

    task automatic t_teach;
        @(posedge clock);
        teach_cmd <= 1'b1;
        pulse(K_TD);
        exp_st[`TSF_B_T_DONE] = 1'b1;
        seen(2);
        cmp_st();
        @(posedge clock);
        teach_cmd <= 1'b0;
        seen(1);
        exp_st[`TSF_B_T_DONE] = 1'b0;
        cmp_st();
        for (int i = 0; i < 2; i++) begin
            pulse(K_TER);
            exp_st[`TSF_B_T_ERR] = 1'b1;
            cmp_st();
            pulse(K_TOV);
            exp_st[`TSF_B_T_OVER] = 1'b1;
            seen(2);
            cmp_st();
            pulse(i == 0 ? K_TOK : K_TAS);
            exp_st[`TSF_B_T_ERR]  = 1'b0;
            exp_st[`TSF_B_T_OVER] = 1'b0;
            cmp_st();
        end
    endtask

    task automatic t_unused;
        tsf_host_i.xfer(`TSF_OFS_STATUS, 1'b1, 32'hffff_ffff, rd_data);
        tsf_host_i.xfer(`TSF_OFS_MCODE, 1'b1, 32'h0000_ffff, rd_data);
        tsf_host_i.xfer(4'hc, 1'b1, 32'hffff_ffff, rd_data);
        tsf_host_i.xfer(`TSF_OFS_STATUS, 1'b0, 32'h0, rd_data);
        chk(rd_data, {16'h0000, exp_st});
        tsf_host_i.xfer(`TSF_OFS_MCODE, 1'b0, 32'h0, rd_data);
        chk(rd_data, 32'h0000_0000);
        tsf_host_i.xfer(`TSF_OFS_CTRL, 1'b0, 32'h0, rd_data);
        chk(rd_data, 32'h0000_0000);
        tsf_host_i.xfer(4'hc, 1'b0, 32'h0, rd_data);
        chk(rd_data, 32'h0000_0000);
    endtask

    initial begin
        repeat (5000) @(posedge clock);
        mismatches++;
        conclude();
    end

    initial begin
        clock = 1'b0;
        arst_n = 1'b0;
        unit_mode = tsf_pkg::TSF_MODE_OTHER;
        {prog_running, program_end_instruction, opt_input_wait} = 3'h0;
        {mcode_reset_wait, mcode_valid, mcode_reset, cycle_start} = 4'h0;
        {teach_cmd, teach_done, teach_ok, teach_err} = 4'h0;
        {teach_addr_over, teach_addr_set_done} = 2'h0;
        mcode_value = 16'h0000;
        mismatches = 0;
        cmp_count = 0;
        repeat (2) @(posedge clock);
        arst_n <= 1'b1;
        @(negedge clock);
        t_reset();
        t_mode();
        t_levels();
        t_done();
        t_mcode();
        t_cstart();
        t_teach();
        t_unused();
        conclude();
    end
endmodule
